// ### cdt_pkg.sv
package cdt_pkg;

  // ==========================================================================
  // Register map
  localparam logic [3:0] CDT_ADDR_IRQ = 4'h4;
  localparam logic [3:0] CDT_ADDR_TEL_A = 4'h5;
  localparam logic [3:0] CDT_ADDR_TEL_B = 4'h6;
  localparam logic [3:0] CDT_ADDR_AUD_A = 4'h7;
  localparam logic [3:0] CDT_ADDR_AUD_B = 4'h8;
  localparam logic [3:0] CDT_ADDR_TOUCH = 4'h9;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] CDT_RST_TEL_A = 16'h0010;
  localparam logic [15:0] CDT_RST_TEL_B = 16'h0000;
  localparam logic [15:0] CDT_RST_AUD_A = 16'h0009;
  localparam logic [15:0] CDT_RST_AUD_B = 16'h0000;
  localparam logic [15:0] CDT_RST_TOUCH = 16'h0000;

  // ==========================================================================
  // Writable bits of each register
  localparam logic [15:0] CDT_MASK_TEL_A = 16'h00ff;
  localparam logic [15:0] CDT_MASK_TEL_B = 16'he848;
  localparam logic [15:0] CDT_MASK_AUD_A = 16'h0fff;
  localparam logic [15:0] CDT_MASK_AUD_B = 16'he11f;
  localparam logic [15:0] CDT_MASK_TOUCH = 16'h000f;

  // ==========================================================================
  // Field positions
  localparam int CDT_DIV_LSB = 0;
  localparam int CDT_DIV_MSB = 6;
  localparam int CDT_TELECOM_EXTRA_GAIN_BIT = 7;
  localparam int CDT_TEL_VOICE_BIT = 3;
  localparam int CDT_TEL_CLIP_BIT = 4;
  localparam int CDT_TELECOM_INPUT_ATTENUATE_BIT = 6;
  localparam int CDT_TEL_SIDE_BIT = 11;
  localparam int CDT_MUTE_BIT = 13;
  localparam int CDT_IN_ENA_BIT = 14;
  localparam int CDT_OUT_ENA_BIT = 15;
  localparam int CDT_AUDIO_INPUT_GAIN_CODE_LSB = 7;
  localparam int CDT_AUDIO_INPUT_GAIN_CODE_MSB = 11;
  localparam int CDT_AUDIO_OUTPUT_ATTEN_CODE_LSB = 0;
  localparam int CDT_AUDIO_OUTPUT_ATTEN_CODE_MSB = 4;
  localparam int CDT_AUD_CLIP_BIT = 6;
  localparam int CDT_AUDIO_LOOPBACK_ON_BIT = 8;
  localparam int CDT_IRQ_TEL_BIT = 14;
  localparam int CDT_IRQ_AUD_BIT = 15;
  localparam int CDT_NUM_FLAGS = 4;

  // Flag slots: 0 telecom clip, 1 audio clip, 2 telecom irq, 3 audio irq
  localparam int CDT_FLAG_TEL_CLIP = 0;
  localparam int CDT_FLAG_AUD_CLIP = 1;
  localparam int CDT_FLAG_TEL_IRQ = 2;
  localparam int CDT_FLAG_AUD_IRQ = 3;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [6:0] telecom_rate_divisor;
    logic telecom_extra_gain;
    logic telecom_input_attenuate;
    logic telecom_voiceband_filter_on;
    logic sidetone_suppress_on;
    logic telecom_output_silence;
    logic telecom_rx_path_on;
    logic telecom_tx_path_on;
    logic [6:0] audio_rate_divisor;
    logic [4:0] audio_input_gain_code;
    logic [4:0] audio_output_atten_code;
    logic audio_loopback_on;
    logic audio_output_silence;
    logic audio_rx_path_on;
    logic audio_tx_path_on;
    logic panel_x_minus_drive;
    logic panel_x_plus_drive;
    logic panel_y_minus_drive;
    logic panel_y_plus_drive;
  } cdt_ctl_t;

  typedef struct packed {
    logic [15:0] tel_a;
    logic [15:0] tel_b;
    logic [15:0] aud_a;
    logic [15:0] aud_b;
    logic [15:0] touch;
    logic [15:0] rdata;
    logic rvalid;
    cdt_ctl_t ctl;
    logic [1:0] tel_sync;
    logic [1:0] aud_sync;
    logic tel_prev;
    logic aud_prev;
  } cdt_state_t;

  typedef struct packed {
    logic flag;
    logic last_written;
  } cdt_flag_state_t;

endpackage

// ### cdt_sticky_flag.sv
`timescale 1ns/10ps
module cdt_sticky_flag
  import cdt_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic set_in,
  input wire logic wr_in,
  input wire logic wbit_in,
  output logic flag_out
);

  cdt_flag_state_t st;
  cdt_flag_state_t next_st;
  logic clear;

  // ==========================================================================
  // Set wins over a clear in the same cycle
  always_comb begin
    next_st = st;
    clear = wr_in && wbit_in && !st.last_written; // R21
    if (wr_in) begin
      next_st.last_written = wbit_in;
    end
    next_st.flag = set_in || (st.flag && !clear);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag_out = st.flag;

  // ==========================================================================
  // Checks
  edge_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R21
    (wr_in && wbit_in && !st.last_written && !set_in) |=> !flag_out)
    else $error("flag not cleared by rising write");
  level_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R21
    (wr_in && wbit_in && st.last_written && st.flag) |=> flag_out)
    else $error("flag cleared without rising write");

endmodule

// ### cdt_regs.sv
`timescale 1ns/10ps
//==============================================================================
// Notes on behaviour
// R1: Interrupt register bit 14 clears telecom clip interrupt on 0-to-1 write; reads pending.
// R2: Interrupt register bit 15 clears audio clip interrupt on 0-to-1 write; reads pending.
// R3: Telecom control A bits 0-6 hold rate divisor, reset 16; software uses 16-127.
// R4: Telecom control A bit 7 enables extra 6 dB telecom input gain.
// R5: Telecom control B bit 3 enables the telecom voice-band filter.
// R6: Telecom control B bit 4 reads sticky telecom clip flag; 0-to-1 write clears.
// R7: Telecom control B bit 6 attenuates telecom input and overrides extra gain.
// R8: Telecom control B bit 11 turns on sidetone suppression.
// R9: Telecom control B bit 13 mutes the telecom output.
// R10: Telecom control B bit 14 turns on the telecom input path.
// R11: Telecom control B bit 15 turns on the telecom output path.
// R12: Audio control A bits 0-6 hold rate divisor, reset 9; software uses 6-127.
// R13: Audio control A bits 7-11 hold input gain code, 0 to 46.5 dB.
// R14: Audio control B bits 0-4 hold output attenuation code, 0 to 69 dB.
// R15: Audio control B bit 6 reads sticky audio clip flag; 0-to-1 write clears.
// R16: Audio control B bit 8 places the audio codec in loopback.
// R17: Audio control B bit 13 mutes the audio output.
// R18: Audio control B bit 14 turns on the audio input path.
// R19: Audio control B bit 15 turns on the audio output path.
// R20: Touch control bits 0-3 power minus-X, plus-X, minus-Y, plus-Y electrodes.
// R21: Clear bits act only on a 0-to-1 change against the last written value.
module cdt_regs
  import cdt_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic tel_clip_in,
  input wire logic aud_clip_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output cdt_ctl_t ctl_out,
  output logic tel_clip_irq_pending_out,
  output logic aud_clip_irq_pending_out
);

  cdt_state_t st;
  cdt_state_t next_st;
  logic [CDT_NUM_FLAGS-1:0] flag_set;
  logic [CDT_NUM_FLAGS-1:0] flag_wr;
  logic [CDT_NUM_FLAGS-1:0] flag_wbit;
  logic [CDT_NUM_FLAGS-1:0] flags;
  logic [15:0] irq_word;

  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] target);
    reg_hit = (addr == target);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                        input logic [15:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // ==========================================================================
  // Sticky flags and their clear bits
  assign flag_set[CDT_FLAG_TEL_CLIP] = st.tel_sync[1]; // R6
  assign flag_set[CDT_FLAG_AUD_CLIP] = st.aud_sync[1]; // R15
  assign flag_set[CDT_FLAG_TEL_IRQ] = st.tel_sync[1] && !st.tel_prev; // R1
  assign flag_set[CDT_FLAG_AUD_IRQ] = st.aud_sync[1] && !st.aud_prev; // R2
  assign flag_wr[CDT_FLAG_TEL_CLIP] = reg_wr_in && reg_hit(reg_addr_in, CDT_ADDR_TEL_B);
  assign flag_wr[CDT_FLAG_AUD_CLIP] = reg_wr_in && reg_hit(reg_addr_in, CDT_ADDR_AUD_B);
  assign flag_wr[CDT_FLAG_TEL_IRQ] = reg_wr_in && reg_hit(reg_addr_in, CDT_ADDR_IRQ);
  assign flag_wr[CDT_FLAG_AUD_IRQ] = reg_wr_in && reg_hit(reg_addr_in, CDT_ADDR_IRQ);
  assign flag_wbit[CDT_FLAG_TEL_CLIP] = reg_wdata_in[CDT_TEL_CLIP_BIT]; // R6
  assign flag_wbit[CDT_FLAG_AUD_CLIP] = reg_wdata_in[CDT_AUD_CLIP_BIT]; // R15
  assign flag_wbit[CDT_FLAG_TEL_IRQ] = reg_wdata_in[CDT_IRQ_TEL_BIT]; // R1
  assign flag_wbit[CDT_FLAG_AUD_IRQ] = reg_wdata_in[CDT_IRQ_AUD_BIT]; // R2

  genvar gi;
  generate
    for (gi = 0; gi < CDT_NUM_FLAGS; gi++) begin : g_flag
      cdt_sticky_flag u_flag (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .set_in(flag_set[gi]),
        .wr_in(flag_wr[gi]),
        .wbit_in(flag_wbit[gi]),
        .flag_out(flags[gi])
      );
    end
  endgenerate

  always_comb begin
    irq_word = '0;
    irq_word[CDT_IRQ_TEL_BIT] = flags[CDT_FLAG_TEL_IRQ]; // R1
    irq_word[CDT_IRQ_AUD_BIT] = flags[CDT_FLAG_AUD_IRQ]; // R2
  end

  // ==========================================================================
  // Register writes, reads and decoded controls
  always_comb begin
    next_st = st;
    // Clip inputs come from the analog side, two stages before use
    next_st.tel_sync = {st.tel_sync[0], tel_clip_in};
    next_st.aud_sync = {st.aud_sync[0], aud_clip_in};
    next_st.tel_prev = st.tel_sync[1];
    next_st.aud_prev = st.aud_sync[1];

    if (reg_wr_in) begin
      if (reg_hit(reg_addr_in, CDT_ADDR_TEL_A)) begin
        next_st.tel_a = merge(st.tel_a, reg_wdata_in, CDT_MASK_TEL_A); // R3
      end
      if (reg_hit(reg_addr_in, CDT_ADDR_TEL_B)) begin
        next_st.tel_b = merge(st.tel_b, reg_wdata_in, CDT_MASK_TEL_B);
      end
      if (reg_hit(reg_addr_in, CDT_ADDR_AUD_A)) begin
        next_st.aud_a = merge(st.aud_a, reg_wdata_in, CDT_MASK_AUD_A); // R12
      end
      if (reg_hit(reg_addr_in, CDT_ADDR_AUD_B)) begin
        next_st.aud_b = merge(st.aud_b, reg_wdata_in, CDT_MASK_AUD_B);
      end
      if (reg_hit(reg_addr_in, CDT_ADDR_TOUCH)) begin
        next_st.touch = merge(st.touch, reg_wdata_in, CDT_MASK_TOUCH);
      end
    end

    next_st.rvalid = reg_rd_in;
    next_st.rdata = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        CDT_ADDR_IRQ: begin
          next_st.rdata = irq_word;
        end
        CDT_ADDR_TEL_A: begin
          next_st.rdata = st.tel_a;
        end
        CDT_ADDR_TEL_B: begin
          next_st.rdata = st.tel_b;
          next_st.rdata[CDT_TEL_CLIP_BIT] = flags[CDT_FLAG_TEL_CLIP]; // R6
        end
        CDT_ADDR_AUD_A: begin
          next_st.rdata = st.aud_a;
        end
        CDT_ADDR_AUD_B: begin
          next_st.rdata = st.aud_b;
          next_st.rdata[CDT_AUD_CLIP_BIT] = flags[CDT_FLAG_AUD_CLIP]; // R15
        end
        CDT_ADDR_TOUCH: begin
          next_st.rdata = st.touch;
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end

    next_st.ctl.telecom_rate_divisor = st.tel_a[CDT_DIV_MSB:CDT_DIV_LSB]; // R3
    next_st.ctl.telecom_input_attenuate = st.tel_b[CDT_TELECOM_INPUT_ATTENUATE_BIT]; // R7
    next_st.ctl.telecom_extra_gain = st.tel_a[CDT_TELECOM_EXTRA_GAIN_BIT] && !st.tel_b[CDT_TELECOM_INPUT_ATTENUATE_BIT]; // R4 R7
    next_st.ctl.telecom_voiceband_filter_on = st.tel_b[CDT_TEL_VOICE_BIT]; // R5
    next_st.ctl.sidetone_suppress_on = st.tel_b[CDT_TEL_SIDE_BIT]; // R8
    next_st.ctl.telecom_output_silence = st.tel_b[CDT_MUTE_BIT]; // R9
    next_st.ctl.telecom_rx_path_on = st.tel_b[CDT_IN_ENA_BIT]; // R10
    next_st.ctl.telecom_tx_path_on = st.tel_b[CDT_OUT_ENA_BIT]; // R11
    next_st.ctl.audio_rate_divisor = st.aud_a[CDT_DIV_MSB:CDT_DIV_LSB]; // R12
    next_st.ctl.audio_input_gain_code = st.aud_a[CDT_AUDIO_INPUT_GAIN_CODE_MSB:CDT_AUDIO_INPUT_GAIN_CODE_LSB]; // R13
    next_st.ctl.audio_output_atten_code = st.aud_b[CDT_AUDIO_OUTPUT_ATTEN_CODE_MSB:CDT_AUDIO_OUTPUT_ATTEN_CODE_LSB]; // R14
    next_st.ctl.audio_loopback_on = st.aud_b[CDT_AUDIO_LOOPBACK_ON_BIT]; // R16
    next_st.ctl.audio_output_silence = st.aud_b[CDT_MUTE_BIT]; // R17
    next_st.ctl.audio_rx_path_on = st.aud_b[CDT_IN_ENA_BIT]; // R18
    next_st.ctl.audio_tx_path_on = st.aud_b[CDT_OUT_ENA_BIT]; // R19
    next_st.ctl.panel_x_minus_drive = st.touch[0]; // R20
    next_st.ctl.panel_x_plus_drive = st.touch[1]; // R20
    next_st.ctl.panel_y_minus_drive = st.touch[2]; // R20
    next_st.ctl.panel_y_plus_drive = st.touch[3]; // R20
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.tel_a <= CDT_RST_TEL_A;
      st.tel_b <= CDT_RST_TEL_B;
      st.aud_a <= CDT_RST_AUD_A;
      st.aud_b <= CDT_RST_AUD_B;
      st.touch <= CDT_RST_TOUCH;
      st.ctl.telecom_rate_divisor <= CDT_RST_TEL_A[CDT_DIV_MSB:CDT_DIV_LSB];
      st.ctl.audio_rate_divisor <= CDT_RST_AUD_A[CDT_DIV_MSB:CDT_DIV_LSB];
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out = st.rdata;
  assign reg_rvalid_out = st.rvalid;
  assign ctl_out = st.ctl;
  assign tel_clip_irq_pending_out = flags[CDT_FLAG_TEL_IRQ];
  assign aud_clip_irq_pending_out = flags[CDT_FLAG_AUD_IRQ];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  read_answer_a: assert property (reg_rd_in |=> reg_rvalid_out ##1 !reg_rvalid_out || $past(reg_rd_in))
    else $error("read answer not one cycle after request");
  tel_irq_read_a: assert property (reg_rd_in && reg_addr_in == CDT_ADDR_IRQ // R1
    |=> reg_rdata_out[CDT_IRQ_TEL_BIT] == $past(flags[CDT_FLAG_TEL_IRQ]))
    else $error("telecom irq status misread");
  aud_irq_set_a: assert property ($rose(aud_clip_in) ##1 aud_clip_in // R2
    |-> ##2 aud_clip_irq_pending_out)
    else $error("audio irq not pending after clip");
  telecom_rate_divisor_write_a: assert property (reg_wr_in && reg_addr_in == CDT_ADDR_TEL_A // R3
    |=> ##1 ctl_out.telecom_rate_divisor == $past(reg_wdata_in[CDT_DIV_MSB:CDT_DIV_LSB], 2))
    else $error("telecom divisor not taken");
  gain_override_a: assert property (ctl_out.telecom_input_attenuate // R7
    |-> !ctl_out.telecom_extra_gain)
    else $error("extra gain active under attenuation");
  tel_clip_hold_a: assert property (flags[CDT_FLAG_TEL_CLIP] && !flag_wr[CDT_FLAG_TEL_CLIP] // R6
    |=> flags[CDT_FLAG_TEL_CLIP])
    else $error("telecom clip flag dropped");
  aud_paths_a: assert property (reg_wr_in && reg_addr_in == CDT_ADDR_AUD_B // R19
    |=> ##1 ctl_out.audio_tx_path_on == $past(reg_wdata_in[CDT_OUT_ENA_BIT], 2)
        && ctl_out.audio_rx_path_on == $past(reg_wdata_in[CDT_IN_ENA_BIT], 2))
    else $error("audio path enables not taken");
  unmapped_read_a: assert property (reg_rd_in && (reg_addr_in < CDT_ADDR_IRQ
    || reg_addr_in > CDT_ADDR_TOUCH) |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  panel_drive_a: assert property (reg_wr_in && reg_addr_in == CDT_ADDR_TOUCH // R20
    |=> ##1 ctl_out.panel_y_plus_drive == $past(reg_wdata_in[3], 2))
    else $error("panel drive not taken");

endmodule

// ### cdt_host_model.sv
`timescale 1ns/10ps
module cdt_host_model (
  input wire logic ref_clk_in,
  input wire logic rvalid_in,
  input wire logic [15:0] rdata_in,
  output logic wr_out,
  output logic rd_out,
  output logic [3:0] addr_out,
  output logic [15:0] wdata_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 4'h0;
    wdata_out = 16'h0000;
  end

  // ==========================================================================
  // Accesses start on a falling edge and are taken on the next rising edge
  task automatic write(input logic [3:0] a, input logic [15:0] d);
    wr_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(negedge ref_clk_in);
    wr_out = 1'b0;
    // Released lines do not keep showing the last value
    addr_out = ~a;
    wdata_out = ~d;
    @(negedge ref_clk_in);
  endtask

  task automatic read(input logic [3:0] a, output logic [16:0] vd);
    rd_out = 1'b1;
    addr_out = a;
    @(negedge ref_clk_in);
    vd = {rvalid_in, rdata_in};
    rd_out = 1'b0;
    addr_out = ~a;
    @(negedge ref_clk_in);
  endtask
endmodule

// ### codec_touch_control_regs_tb.sv
`timescale 1ns/10ps
module codec_touch_control_regs_tb;
  import cdt_pkg::*;
  logic ref_clk_in, rst_n_in, tel_clip_in, aud_clip_in, reg_wr_in, reg_rd_in;
  logic reg_rvalid_out, tel_pend, aud_pend;
  logic [3:0] reg_addr_in, fa;
  logic [15:0] reg_wdata_in, reg_rdata_out, fv, iv;
  cdt_ctl_t ctl_out;
  int failures = 0;
  int samples_checked = 0;
  logic [15:0] rstv [6] = '{16'h0000, CDT_RST_TEL_A, CDT_RST_TEL_B, CDT_RST_AUD_A,
                            CDT_RST_AUD_B, CDT_RST_TOUCH};
  logic [15:0] msk [5] = '{CDT_MASK_TEL_A, CDT_MASK_TEL_B, CDT_MASK_AUD_A, CDT_MASK_AUD_B,
                           CDT_MASK_TOUCH};
  // Divisors stay inside 16..127 (telecom) and 6..127 (audio)
  logic [15:0] pat [4][5] = '{'{16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff},
                              '{16'h0010, 16'h0000, 16'h0006, 16'h0000, 16'h0000},
                              '{16'h0095, 16'h0000, 16'h0a86, 16'h2115, 16'h0005},
                              '{16'h00aa, 16'h4808, 16'h057f, 16'hc00a, 16'h000a}};

  cdt_regs DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .tel_clip_in(tel_clip_in), .aud_clip_in(aud_clip_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .ctl_out(ctl_out),
    .tel_clip_irq_pending_out(tel_pend), .aud_clip_irq_pending_out(aud_pend));

  cdt_host_model host (.ref_clk_in(ref_clk_in), .rvalid_in(reg_rvalid_out),
    .rdata_in(reg_rdata_out), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
    .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  // ==========================================================================
  // Checking helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    logic [16:0] v;
    host.read(a, v);
    check({47'h0, v}, {47'h0, 1'b1, e});
  endtask

  function automatic cdt_ctl_t exp_ctl(input logic [15:0] ta, input logic [15:0] tb_,
                                       input logic [15:0] aa, input logic [15:0] ab,
                                       input logic [15:0] tc);
    return {ta[6:0], ta[7] & ~tb_[6], tb_[6], tb_[3], tb_[11], tb_[13], tb_[14], tb_[15],
            aa[6:0], aa[11:7], ab[4:0], ab[8], ab[13], ab[14], ab[15],
            tc[0], tc[1], tc[2], tc[3]};
  endfunction

  task automatic pulse(input int i);
    if (i == 0) tel_clip_in = 1'b1;
    else aud_clip_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    tel_clip_in = 1'b0;
    aud_clip_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
  endtask

  task automatic test_done;
    $display("Compared %0d values, %0d mismatches", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    failures++;
    test_done;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    tel_clip_in = 1'b0;
    aud_clip_in = 1'b0;
    repeat (10) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    @(negedge ref_clk_in);
    for (int a = 4; a < 10; a++) rdchk(4'(a), rstv[a-4]);
    check({25'h0, ctl_out}, {25'h0, exp_ctl(16'h0010, 0, 16'h0009, 0, 0)});
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 5; k++) host.write(4'(k + 5), pat[r][k]);
      repeat (2) @(negedge ref_clk_in);
      for (int k = 0; k < 5; k++) rdchk(4'(k + 5), pat[r][k] & msk[k]);
      check({25'h0, ctl_out}, {25'h0, exp_ctl(pat[r][0], pat[r][1], pat[r][2], pat[r][3],
            pat[r][4])});
    end
    // Unmapped indices
    host.write(4'ha, 16'hffff);
    rdchk(4'h3, 16'h0000);
    rdchk(4'ha, 16'h0000);
    rdchk(4'h5, pat[3][0] & msk[0]);
    // Clip flags and clip interrupts, telecom then audio
    for (int i = 0; i < 2; i++) begin
      fa = (i == 0) ? CDT_ADDR_TEL_B : CDT_ADDR_AUD_B;
      fv = (i == 0) ? 16'h0010 : 16'h0040;
      iv = (i == 0) ? 16'h4000 : 16'h8000;
      host.write(CDT_ADDR_IRQ, 16'h0000);
      host.write(fa, 16'h0000);
      pulse(i);
      rdchk(fa, fv);
      rdchk(CDT_ADDR_IRQ, iv);
      check({62'h0, tel_pend, aud_pend}, {62'h0, i == 0, i == 1});
      host.write(CDT_ADDR_IRQ, iv);
      rdchk(CDT_ADDR_IRQ, 16'h0000);
      check({62'h0, tel_pend, aud_pend}, 64'h0);
      rdchk(fa, fv);
      host.write(fa, fv);
      rdchk(fa, 16'h0000);
      pulse(i);
      host.write(CDT_ADDR_IRQ, iv);
      rdchk(CDT_ADDR_IRQ, iv);
      host.write(fa, fv);
      rdchk(fa, fv);
      host.write(CDT_ADDR_IRQ, 16'h0000);
      host.write(CDT_ADDR_IRQ, iv);
      rdchk(CDT_ADDR_IRQ, 16'h0000);
      host.write(fa, 16'h0000);
      host.write(fa, fv);
      rdchk(fa, 16'h0000);
    end
    // Mid-run reset returns every register to its reset value
    rst_n_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    @(negedge ref_clk_in);
    for (int a = 4; a < 10; a++) rdchk(4'(a), rstv[a-4]);
    check({25'h0, ctl_out}, {25'h0, exp_ctl(16'h0010, 0, 16'h0009, 0, 0)});
    test_done;
  end
endmodule
